// *** rtl/fbf_fifo.sv ***
// Generic synchronous FIFO with flush, fill count and valid/ready on both sides.
`timescale 1ns/1ps
module fbf_fifo #(
  parameter int W = 8,
  parameter int D = 4,
  parameter int CW = $clog2(D + 1)
) (
  input  wire logic          i_mclk,     // Clock.
  input  wire logic          i_sys_rst,  // Asynchronous reset.
  input  wire logic          i_flush,    // Empty the FIFO at once.
  input  wire logic          i_wr_valid, // Write request.
  output logic               o_wr_ready, // Room for a word.
  input  wire logic [W-1:0]  i_wr_data,  // Word to store.
  output logic               o_rd_valid, // A word is held.
  input  wire logic          i_rd_ready, // Consumer takes head.
  output logic [W-1:0]       o_rd_data,  // Head word.
  output logic [CW-1:0]      o_count     // Words held.
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [CW-1:0] cnt_reg;
  wire           push = i_wr_valid && o_wr_ready;
  wire           pop  = o_rd_valid && i_rd_ready;
  wire [AW-1:0]  wp_inc = (wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1;
  wire [AW-1:0]  rp_inc = (rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1;

  assign o_wr_ready = (cnt_reg != CW'(D));
  assign o_rd_valid = (cnt_reg != '0);
  assign o_rd_data  = mem[rp_reg];
  assign o_count    = cnt_reg;

  always_ff @(posedge i_mclk)
  begin
    if (push)
      mem[wp_reg] <= i_wr_data;
  end

  // Flush wins over a same-cycle push or pop so the pointers end up equal.
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else if (i_flush)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wp_reg <= wp_inc;
      if (pop)
        rp_reg <= rp_inc;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule : fbf_fifo

// *** rtl/fbf_pkg.sv ***
// Shared constants for the FIFO and bit-framing control block.
package fbf_pkg;
  localparam int          FIFO_DEPTH     = 64;
  localparam int          RX_BUF_DEPTH   = 4;
  localparam int          ID_BYTES       = 10;
  localparam logic [5:0]  ADDR_DATA_PORT = 6'h09;
  localparam logic [5:0]  ADDR_LEVEL     = 6'h0a;
  localparam logic [5:0]  ADDR_THRESH    = 6'h0b;
  localparam logic [5:0]  ADDR_CONTROL   = 6'h0c;
  localparam logic [5:0]  ADDR_FRAMING   = 6'h0d;
  localparam int          LVL_FLUSH_BIT  = 7;
  localparam int          CTL_HALT_BIT   = 7;
  localparam int          CTL_GO_BIT     = 6;
  localparam int          CTL_COPY_BIT   = 5;
  localparam int          CTL_INIT_BIT   = 4;
  localparam int          BFA_LAUNCH_BIT = 7;
  localparam int          BFA_ALIGN_LSB  = 4;
  localparam int          BFA_TXBITS_LSB = 0;
  localparam logic [5:0]  THRESH_RESET   = 6'h08;
  localparam logic        INIT_RESET     = 1'h0;
  localparam logic [2:0]  ALIGN_RESET    = 3'h0;
  localparam logic [2:0]  TXBITS_RESET   = 3'h0;
  localparam logic [2:0]  PHASE_IDLE     = 3'h0;
  localparam logic [2:0]  PHASE_WAIT_GO  = 3'h1;
  localparam logic [2:0]  PHASE_SENDING  = 3'h3;
  localparam logic [2:0]  PHASE_WAIT_RX  = 3'h5;
endpackage : fbf_pkg

// *** rtl/fbf_rx_packer.sv ***
// Packs received bits into bytes starting at a chosen bit position.
`timescale 1ns/1ps
module fbf_rx_packer (
  input  wire logic        i_mclk,      // Clock.
  input  wire logic        i_sys_rst,   // Asynchronous reset.
  input  wire logic [2:0]  i_align,     // Position of the first bit.
  input  wire logic        i_start,     // Frame start pulse.
  input  wire logic        i_bit_valid, // Received bit strobe.
  input  wire logic        i_bit,       // Received bit value.
  output logic             o_bit_ready, // Bit can be taken.
  input  wire logic        i_end,       // Frame end pulse.
  output logic             o_valid,     // Packed byte ready.
  input  wire logic        i_ready,     // Byte taken.
  output logic [7:0]       o_byte,      // Packed byte.
  output logic             o_done,      // Frame closed pulse.
  output logic [2:0]       o_last_bits  // Valid bits of last byte.
);
  logic [7:0] acc_reg;
  logic [2:0] pos_reg;
  logic       any_reg;
  logic       done_reg;
  logic [2:0] last_reg;
  logic       out_v_reg;
  logic [7:0] out_b_reg;

  wire       bit_take = i_bit_valid && o_bit_ready;
  wire [7:0] acc_bit  = acc_reg | ({7'h00, i_bit} << pos_reg);
  wire       byte_ful = bit_take && (pos_reg == 3'h7);
  // A partial byte is flushed at the end only if it holds received bits.
  wire       part_out = i_end && any_reg && o_bit_ready;
  wire       out_take = out_v_reg && i_ready;

  assign o_bit_ready = !out_v_reg || i_ready;
  assign o_valid     = out_v_reg;
  assign o_byte      = out_b_reg;
  assign o_done      = done_reg;
  assign o_last_bits = last_reg;

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      acc_reg   <= 8'h00;
      pos_reg   <= 3'h0;
      any_reg   <= 1'b0;
      done_reg  <= 1'b0;
      last_reg  <= 3'h0;
      out_v_reg <= 1'b0;
      out_b_reg <= 8'h00;
    end
    else
    begin
      done_reg <= i_end;
      if (out_take)
        out_v_reg <= 1'b0;
      if (i_start)
      begin
        acc_reg <= 8'h00;
        pos_reg <= i_align;
        any_reg <= 1'b0;
      end
      else if (byte_ful)
      begin
        out_b_reg <= acc_bit;
        out_v_reg <= 1'b1;
        acc_reg   <= 8'h00;
        pos_reg   <= 3'h0;
        any_reg   <= 1'b0;
      end
      else if (bit_take)
      begin
        acc_reg <= acc_bit;
        pos_reg <= pos_reg + 3'h1;
        any_reg <= 1'b1;
      end
      else if (part_out)
      begin
        out_b_reg <= acc_reg;
        out_v_reg <= 1'b1;
        acc_reg   <= 8'h00;
        any_reg   <= 1'b0;
      end
      if (i_end)
        last_reg <= pos_reg;
    end
  end
endmodule : fbf_rx_packer

// *** rtl/fbf_top.sv ***
// FIFO buffer, fill level, warnings, control and bit-framing registers.
//
// Functional notes
// - 64-byte FIFO behind one byte data port.
// - FIFO buffers every serial stream both ways.
// - Flush bit clears pointers and overrun; reads 0.
// - Read-only fill count in level bits 6..0.
// - Near-full when free space <= threshold.
// - Near-empty when count <= threshold; resets 8.
// - Timer halt strobe stops timer; reads 0.
// - Timer go strobe starts timer; reads 0.
// - Copy bit loads 10-byte identifier, self-clears.
// - Role bit: one initiator, zero target.
// - Read-only count of valid last-byte bits.
// - Launch bit starts sending FIFO data.
// - Launch ignored outside send-and-receive command.
// - Alignment sets first received bit position.
// - Alignment seven wraps second bit to next byte.
// - Last-bits field sets bits sent of final byte.
// - Waiting for launch reports phase 001.
`timescale 1ns/1ps
module fbf_top #(
  parameter int DEPTH    = fbf_pkg::FIFO_DEPTH,
  parameter int RX_DEPTH = fbf_pkg::RX_BUF_DEPTH,
  parameter int ID_LEN   = fbf_pkg::ID_BYTES
) (
  input  wire logic               i_mclk,            // 125 MHz clock.
  input  wire logic               i_sys_rst,         // Async reset, high.
  input  wire logic [5:0]         i_reg_addr,        // Register address.
  input  wire logic               i_reg_wr,          // Register write strobe.
  input  wire logic               i_reg_rd,          // Register read strobe.
  input  wire logic [7:0]         i_reg_wdata,       // Write data.
  output logic [7:0]              o_reg_rdata,       // Read data.
  output logic                    o_reg_rvalid,      // Read data valid pulse.
  input  wire logic               i_cmd_transceive,  // Send-and-receive active.
  output logic [2:0]              o_modem_phase,     // Modem phase code.
  output logic                    o_tx_valid,        // Transmit byte offered.
  input  wire logic               i_tx_ready,        // Transmitter takes byte.
  output logic [7:0]              o_tx_byte,         // Transmit byte.
  output logic                    o_tx_last,         // Final byte of frame.
  output logic [2:0]              o_last_tx_bit_count, // Bits of final byte.
  input  wire logic               i_rx_start,        // Receive frame start.
  input  wire logic               i_rx_bit_valid,    // Received bit strobe.
  input  wire logic               i_rx_bit,          // Received bit.
  output logic                    o_rx_bit_ready,    // Bit accepted.
  input  wire logic               i_rx_end,          // Receive frame end.
  input  wire logic [8*ID_LEN-1:0] i_stored_target_id, // Identifier, byte 0 low.
  output logic                    o_timer_halt,      // Timer stop pulse.
  output logic                    o_timer_go,        // Timer start pulse.
  output logic                    o_initiator,       // Role: 1 initiator.
  output logic                    o_overrun_flag,    // Buffer overflow error.
  output logic                    o_near_full_alert, // Little space left.
  output logic                    o_near_empty_alert // Few bytes held.
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int IW = $clog2(ID_LEN + 1);

  typedef enum logic [1:0] {
    FBF_IDLE,
    FBF_WAIT_GO,
    FBF_SENDING,
    FBF_WAIT_RX
  } fbf_phase_t;

  //////////////////////////////////////////////////////////////////////////////
  // Register access decode.

  wire wr_data  = i_reg_wr && (i_reg_addr == fbf_pkg::ADDR_DATA_PORT);
  wire wr_level = i_reg_wr && (i_reg_addr == fbf_pkg::ADDR_LEVEL);
  wire wr_thr   = i_reg_wr && (i_reg_addr == fbf_pkg::ADDR_THRESH);
  wire wr_ctl   = i_reg_wr && (i_reg_addr == fbf_pkg::ADDR_CONTROL);
  wire wr_bfa   = i_reg_wr && (i_reg_addr == fbf_pkg::ADDR_FRAMING);
  wire rd_data  = i_reg_rd && (i_reg_addr == fbf_pkg::ADDR_DATA_PORT);

  wire flush    = wr_level && i_reg_wdata[fbf_pkg::LVL_FLUSH_BIT];
  wire halt_wr  = wr_ctl && i_reg_wdata[fbf_pkg::CTL_HALT_BIT];
  wire go_wr    = wr_ctl && i_reg_wdata[fbf_pkg::CTL_GO_BIT];
  wire copy_wr  = wr_ctl && i_reg_wdata[fbf_pkg::CTL_COPY_BIT];
  // A launch outside the send-and-receive command is simply dropped.
  wire launch   = wr_bfa && i_reg_wdata[fbf_pkg::BFA_LAUNCH_BIT]
                  && i_cmd_transceive;

  //////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [5:0]    thr_reg;
  logic          init_reg;
  logic [2:0]    align_reg;
  logic [2:0]    txbits_reg;
  logic [2:0]    rxbits_reg;
  logic          ovf_reg;
  logic          halt_reg;
  logic          go_reg;
  logic          copy_reg;
  logic [IW-1:0] copy_idx_reg;
  logic [7:0]    rdata_reg;
  logic          rvalid_reg;
  fbf_phase_t    phase_reg;
  fbf_phase_t    phase_next;

  //////////////////////////////////////////////////////////////////////////////
  // Main FIFO write arbitration: host, then identifier copy, then receiver.

  logic          m_wr_ready;
  logic          m_rd_valid;
  logic [7:0]    m_rd_data;
  logic [CW-1:0] m_count;
  logic          rb_valid;
  logic [7:0]    rb_data;
  logic          pk_valid;
  logic          pk_ready;
  logic [7:0]    pk_byte;
  logic          pk_done;
  logic [2:0]    pk_last;

  wire       copy_take = copy_reg && !wr_data && m_wr_ready;
  wire       rb_take   = rb_valid && !wr_data && !copy_reg && m_wr_ready;
  wire [7:0] id_byte   = i_stored_target_id[8 * copy_idx_reg +: 8];
  wire       m_wr_v    = wr_data || copy_reg || rb_valid;
  wire [7:0] m_wr_d    = wr_data  ? i_reg_wdata :
                         copy_reg ? id_byte : rb_data;
  wire       host_ovf  = wr_data && !m_wr_ready;

  // Host pops win; the transmitter waits for a cycle without one.
  wire       sending   = (phase_reg == FBF_SENDING);
  wire       tx_fire   = o_tx_valid && i_tx_ready;
  wire       m_pop     = (rd_data && m_rd_valid) || tx_fire;

  fbf_fifo #(
    .W  (8),
    .D  (DEPTH),
    .CW (CW)
  ) u_main_fifo (
    .i_mclk     (i_mclk),
    .i_sys_rst  (i_sys_rst),
    .i_flush    (flush),
    .i_wr_valid (m_wr_v),
    .o_wr_ready (m_wr_ready),
    .i_wr_data  (m_wr_d),
    .o_rd_valid (m_rd_valid),
    .i_rd_ready (m_pop),
    .o_rd_data  (m_rd_data),
    .o_count    (m_count)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Receive path: bit packer feeding a small buffer in front of the main FIFO.

  fbf_rx_packer u_packer (
    .i_mclk      (i_mclk),
    .i_sys_rst   (i_sys_rst),
    .i_align     (align_reg),
    .i_start     (i_rx_start),
    .i_bit_valid (i_rx_bit_valid),
    .i_bit       (i_rx_bit),
    .o_bit_ready (o_rx_bit_ready),
    .i_end       (i_rx_end),
    .o_valid     (pk_valid),
    .i_ready     (pk_ready),
    .o_byte      (pk_byte),
    .o_done      (pk_done),
    .o_last_bits (pk_last)
  );

  // The buffer absorbs bursts while the host owns the write side; when it
  // fills, the packer stops taking bits and the receiver must hold off.
  fbf_fifo #(
    .W  (8),
    .D  (RX_DEPTH),
    .CW ($clog2(RX_DEPTH + 1))
  ) u_rx_buf (
    .i_mclk     (i_mclk),
    .i_sys_rst  (i_sys_rst),
    .i_flush    (flush),
    .i_wr_valid (pk_valid),
    .o_wr_ready (pk_ready),
    .i_wr_data  (pk_byte),
    .o_rd_valid (rb_valid),
    .i_rd_ready (rb_take),
    .o_rd_data  (rb_data),
    .o_count    ()
  );

  //////////////////////////////////////////////////////////////////////////////
  // Warnings and read-back.

  wire [CW-1:0] free_cnt = CW'(DEPTH) - m_count;
  wire [CW-1:0] thr_ext  = CW'(thr_reg);

  assign o_near_full_alert  = (free_cnt <= thr_ext);
  assign o_near_empty_alert = (m_count <= thr_ext);

  // Strobe bits read back as zero; copy bit reads one while it runs.
  wire [7:0] lvl_rd = {1'b0, 7'(m_count)};
  wire [7:0] thr_rd = {2'b00, thr_reg};
  wire [7:0] ctl_rd = {2'b00, copy_reg, init_reg, 1'b0, rxbits_reg};
  wire [7:0] bfa_rd = {1'b0, align_reg, 1'b0, txbits_reg};
  wire [7:0] rd_mux =
    (i_reg_addr == fbf_pkg::ADDR_DATA_PORT) ? m_rd_data :
    (i_reg_addr == fbf_pkg::ADDR_LEVEL)     ? lvl_rd :
    (i_reg_addr == fbf_pkg::ADDR_THRESH)    ? thr_rd :
    (i_reg_addr == fbf_pkg::ADDR_CONTROL)   ? ctl_rd :
    (i_reg_addr == fbf_pkg::ADDR_FRAMING)   ? bfa_rd : 8'h00;

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= i_reg_rd;
      if (i_reg_rd)
        rdata_reg <= rd_mux;
    end
  end

  assign o_reg_rdata  = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      thr_reg    <= fbf_pkg::THRESH_RESET;
      init_reg   <= fbf_pkg::INIT_RESET;
      align_reg  <= fbf_pkg::ALIGN_RESET;
      txbits_reg <= fbf_pkg::TXBITS_RESET;
    end
    else
    begin
      if (wr_thr)
        thr_reg <= i_reg_wdata[5:0];
      if (wr_ctl)
        init_reg <= i_reg_wdata[fbf_pkg::CTL_INIT_BIT];
      if (wr_bfa)
      begin
        align_reg  <= i_reg_wdata[fbf_pkg::BFA_ALIGN_LSB +: 3];
        txbits_reg <= i_reg_wdata[fbf_pkg::BFA_TXBITS_LSB +: 3];
      end
    end
  end

  assign o_initiator         = init_reg;
  assign o_last_tx_bit_count = txbits_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Strobes, overrun flag, identifier copy and received bit count.

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      halt_reg <= 1'b0;
      go_reg   <= 1'b0;
      ovf_reg  <= 1'b0;
    end
    else
    begin
      halt_reg <= halt_wr;
      go_reg   <= go_wr;
      // Flush and a data write never share a cycle, so set-wins is implicit.
      if (host_ovf)
        ovf_reg <= 1'b1;
      else if (flush)
        ovf_reg <= 1'b0;
    end
  end

  assign o_timer_halt   = halt_reg;
  assign o_timer_go     = go_reg;
  assign o_overrun_flag = ovf_reg;

  // The copy stalls while the FIFO is full rather than dropping bytes.
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      copy_reg     <= 1'b0;
      copy_idx_reg <= '0;
    end
    else if (copy_wr && !copy_reg)
    begin
      copy_reg     <= 1'b1;
      copy_idx_reg <= '0;
    end
    else if (copy_take)
    begin
      copy_idx_reg <= copy_idx_reg + 1'b1;
      if (copy_idx_reg == IW'(ID_LEN - 1))
        copy_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rxbits_reg <= 3'h0;
    else if (pk_done)
      rxbits_reg <= pk_last;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Modem phase sequencing.

  always_comb
  begin
    phase_next = phase_reg;
    if (!i_cmd_transceive)
      phase_next = FBF_IDLE;
    else
      unique case (phase_reg)
        FBF_IDLE:
          phase_next = launch ? FBF_SENDING : FBF_WAIT_GO;
        FBF_WAIT_GO:
          if (launch)
            phase_next = FBF_SENDING;
        FBF_SENDING:
          if (!m_rd_valid || (tx_fire && (m_count == CW'(1))))
            phase_next = FBF_WAIT_RX;
        FBF_WAIT_RX:
          phase_next = FBF_WAIT_RX;
      endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      phase_reg <= FBF_IDLE;
    else
      phase_reg <= phase_next;
  end

  wire [2:0] phase_code =
    (phase_reg == FBF_WAIT_GO) ? fbf_pkg::PHASE_WAIT_GO :
    (phase_reg == FBF_SENDING) ? fbf_pkg::PHASE_SENDING :
    (phase_reg == FBF_WAIT_RX) ? fbf_pkg::PHASE_WAIT_RX : fbf_pkg::PHASE_IDLE;

  assign o_modem_phase = phase_code;

  //////////////////////////////////////////////////////////////////////////////
  // Transmit stream out of the FIFO head.

  assign o_tx_valid = sending && m_rd_valid && !rd_data;
  assign o_tx_byte  = m_rd_data;
  assign o_tx_last  = (m_count == CW'(1));
endmodule : fbf_top

// *** test/fbf_far_model.sv ***
// Far-side model: transmit byte sink and received-bit source.
`timescale 1ns/1ps
module fbf_far_model (
  input  wire logic       i_mclk,         // Clock.
  input  wire logic       i_slow,         // Stall the sink at random.
  input  wire logic       i_tx_valid,     // Byte offered.
  input  wire logic [7:0] i_tx_byte,      // Offered byte.
  input  wire logic       i_tx_last,      // Final byte flag.
  input  wire logic       i_rx_bit_ready, // Block takes a bit.
  output logic            o_tx_ready,     // Sink takes the byte.
  output logic            o_rx_start,     // Frame start pulse.
  output logic            o_rx_bit_valid, // Bit offered.
  output logic            o_rx_bit,       // Bit value.
  output logic            o_rx_end        // Frame end pulse.
);
  logic [8:0] got_q[$];
  logic       taken;
  initial
  begin
    {o_tx_ready, o_rx_start, o_rx_bit_valid, o_rx_bit, o_rx_end} = 5'h00;
  end
  always @(negedge i_mclk) o_tx_ready <= i_slow ? 1'($urandom % 2) : 1'b1;
  always @(posedge i_mclk) if (i_tx_valid && o_tx_ready) got_q.push_back({i_tx_last, i_tx_byte});
  always @(posedge i_mclk) taken <= o_rx_bit_valid && i_rx_bit_ready;
  task automatic send(input logic [15:0] bits, input int n);
    o_rx_start <= 1'b1;
    @(negedge i_mclk);
    o_rx_start <= 1'b0;
    for (int k = 0; k < n; k++)
    begin
      o_rx_bit_valid <= 1'b1;
      o_rx_bit       <= bits[k];
      @(negedge i_mclk);
      while (!taken) @(negedge i_mclk);
    end
    o_rx_bit_valid <= 1'b0;
    // A released line must not keep showing the last bit.
    o_rx_bit       <= ~bits[n-1];
    o_rx_end       <= 1'b1;
    @(negedge i_mclk);
    o_rx_end <= 1'b0;
  endtask : send
endmodule : fbf_far_model

// *** test/fbf_top_asserts.sv ***
// Port-level checks for the FIFO and bit-framing block.
`timescale 1ns/1ps
module fbf_top_asserts (
  input wire logic       i_mclk,           // Clock.
  input wire logic       i_sys_rst,        // Reset.
  input wire logic [5:0] i_reg_addr,       // Address.
  input wire logic       i_reg_wr,         // Write strobe.
  input wire logic       i_reg_rd,         // Read strobe.
  input wire logic [7:0] i_reg_wdata,      // Write data.
  input wire logic       o_reg_rvalid,     // Read valid.
  input wire logic       i_cmd_transceive, // Command active.
  input wire logic [2:0] o_modem_phase,    // Phase code.
  input wire logic       o_tx_valid,       // Byte offered.
  input wire logic       o_timer_halt,     // Halt pulse.
  input wire logic       o_timer_go,       // Go pulse.
  input wire logic       o_initiator,      // Role.
  input wire logic       o_overrun_flag    // Overrun.
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  wire ctl_wr = i_reg_wr && i_reg_addr == 6'h0c;
  wire go_cmd = ctl_wr && i_reg_wdata[6];
  wire go_wr  = i_reg_wr && i_reg_addr == 6'h0d && i_reg_wdata[7];
  wire fl_wr  = i_reg_wr && i_reg_addr == 6'h0a && i_reg_wdata[7];
  wire armed  = i_cmd_transceive && o_modem_phase inside {3'h0, 3'h1};
  sequence s_wait; armed && !go_wr; endsequence
  sequence s_launch; armed && go_wr; endsequence
  property p_rvalid; i_reg_rd |=> o_reg_rvalid; endproperty
  property p_wait; s_wait |=> o_modem_phase == 3'h1; endproperty
  property p_launch; s_launch |=> o_modem_phase == 3'h3; endproperty
  property p_ignore; !i_cmd_transceive |=> o_modem_phase == 3'h0; endproperty
  property p_txv; o_tx_valid |-> o_modem_phase == 3'h3; endproperty
  property p_halt; ctl_wr && i_reg_wdata[7] |=> o_timer_halt; endproperty
  property p_go; go_cmd |=> o_timer_go ##1 (!o_timer_go || $past(go_cmd)); endproperty
  property p_init; ctl_wr |=> o_initiator == $past(i_reg_wdata[4]); endproperty
  property p_flush; fl_wr |=> !o_overrun_flag; endproperty
  property p_sticky; o_overrun_flag && !fl_wr |=> o_overrun_flag; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  a_wait: assert property (p_wait) else $error("phase not waiting");
  a_launch: assert property (p_launch) else $error("launch not taken");
  a_ignore: assert property (p_ignore) else $error("phase not idle");
  a_txv: assert property (p_txv) else $error("tx outside sending");
  a_halt: assert property (p_halt) else $error("halt pulse missing");
  a_go: assert property (p_go) else $error("go pulse wrong");
  a_init: assert property (p_init) else $error("role bit wrong");
  a_flush: assert property (p_flush) else $error("overrun not cleared");
  a_sticky: assert property (p_sticky) else $error("overrun dropped");
endmodule : fbf_top_asserts
bind fbf_top fbf_top_asserts u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_wdata(i_reg_wdata), .o_reg_rvalid(o_reg_rvalid),
  .i_cmd_transceive(i_cmd_transceive), .o_modem_phase(o_modem_phase),
  .o_tx_valid(o_tx_valid), .o_timer_halt(o_timer_halt), .o_timer_go(o_timer_go),
  .o_initiator(o_initiator), .o_overrun_flag(o_overrun_flag));

// *** test/fbf_top_tb.sv ***
// Self-checking bench for the FIFO and bit-framing block.
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 8'(e), 8'(g));
module fbf_top_tb;
  logic        clk, rst, wr_s, rd_s, cmd, txr, rxs, rxv, rxb, rxe, slow;
  logic        rvalid, txv, txl, rxr, halt, go, init, ovf, nf, ne;
  logic [5:0]  addr;
  logic [7:0]  wdata, rdata, txb, v;
  logic [2:0]  phase, txbits;
  logic [79:0] id;
  logic [15:0] bits;
  logic [7:0]  q[$];
  int          mismatches, cmp_count, thr = 8, pos, n;
  fbf_top u_dut (.i_mclk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr_s),
    .i_reg_rd(rd_s), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_cmd_transceive(cmd), .o_modem_phase(phase), .o_tx_valid(txv), .i_tx_ready(txr),
    .o_tx_byte(txb), .o_tx_last(txl), .o_last_tx_bit_count(txbits), .i_rx_start(rxs),
    .i_rx_bit_valid(rxv), .i_rx_bit(rxb), .o_rx_bit_ready(rxr), .i_rx_end(rxe),
    .i_stored_target_id(id), .o_timer_halt(halt), .o_timer_go(go), .o_initiator(init),
    .o_overrun_flag(ovf), .o_near_full_alert(nf), .o_near_empty_alert(ne));
  fbf_far_model u_far (.i_mclk(clk), .i_slow(slow), .i_tx_valid(txv), .i_tx_byte(txb),
    .i_tx_last(txl), .i_rx_bit_ready(rxr), .o_tx_ready(txr), .o_rx_start(rxs),
    .o_rx_bit_valid(rxv), .o_rx_bit(rxb), .o_rx_end(rxe));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic final_report;
    $display("compared %0d, mismatched %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Each access leaves one idle cycle so a strobe never rises where it fell.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(negedge clk);
    wr_s <= 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(negedge clk);
    rd_s <= 1'b0;
    `CHK("rvalid", 1, rvalid)
    d = rdata;
    @(negedge clk);
  endtask : rd
  task automatic exp_rd(input logic [5:0] a, input logic [7:0] e, m = 8'hff);
    rd(a, v);
    `CHK($sformatf("reg %h", a), e & m, v & m)
  endtask : exp_rd
  task automatic alerts;
    `CHK("near_full", (64 - q.size()) <= thr, nf)
    `CHK("near_empty", q.size() <= thr, ne)
  endtask : alerts
  task automatic pops(input int c);
    repeat (c)
    begin
      rd(6'h09, v);
      `CHK("byte", q.pop_front(), v)
      alerts();
    end
  endtask : pops
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(8ns * 20000);
    mismatches++;
    final_report();
  end
  initial
  begin
    {clk, wr_s, rd_s, cmd, slow, addr, wdata, id} = '0;
    rst = 1'b1;
    void'($urandom(32'h5a92733f));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    exp_rd(6'h0a, 8'h00);
    exp_rd(6'h0b, 8'h08);
    exp_rd(6'h0c, 8'h00);
    exp_rd(6'h0d, 8'h00);
    exp_rd(6'h3f, 8'h00);
    alerts();
    $display("test reset done");
    thr = $urandom % 64;
    wr(6'h0b, 8'(thr));
    exp_rd(6'h0b, 8'(thr), 8'h3f);
    for (int i = 0; i < 65; i++)
    begin
      v = 8'($urandom);
      wr(6'h09, v);
      if (q.size() < 64) q.push_back(v);
      alerts();
    end
    `CHK("overrun", 1, ovf)
    exp_rd(6'h0a, 8'h40);
    pops(32);
    wr(6'h0a, 8'h80);
    q.delete();
    `CHK("overrun", 0, ovf)
    exp_rd(6'h0a, 8'h00);
    rd(6'h09, v);
    exp_rd(6'h0a, 8'h00);
    $display("test fifo done");
    wr(6'h0c, 8'hd0);
    `CHK("initiator", 1, init)
    exp_rd(6'h0c, 8'h10, 8'hf0);
    wr(6'h0c, 8'h40);
    `CHK("initiator", 0, init)
    exp_rd(6'h0c, 8'h00, 8'hf0);
    id = {16'($urandom), $urandom, $urandom};
    wr(6'h0c, 8'h20);
    exp_rd(6'h0c, 8'h20, 8'h20);
    repeat (12) @(negedge clk);
    exp_rd(6'h0c, 8'h00, 8'h20);
    for (int k = 0; k < 10; k++) q.push_back(id[8*k +: 8]);
    exp_rd(6'h0a, 8'd10);
    pops(q.size());
    $display("test control done");
    for (int k = 0; k < 5; k++) begin q.push_back(8'($urandom)); wr(6'h09, q[k]); end
    wr(6'h0d, 8'h83);
    `CHK("phase", 0, phase)
    `CHK("tx_bits", 3, txbits)
    cmd  <= 1'b1;
    slow <= 1'b1;
    @(negedge clk);
    `CHK("phase", 1, phase)
    wr(6'h0d, 8'h83);
    for (int k = 0; k < 200 && u_far.got_q.size() < 5; k++) @(negedge clk);
    @(negedge clk);
    `CHK("phase", 5, phase)
    for (int k = 0; k < 5; k++)
    begin
      `CHK("tx_byte", q[k], u_far.got_q[k][7:0])
      `CHK("tx_last", k == 4, u_far.got_q[k][8])
    end
    q.delete();
    cmd <= 1'b0;
    $display("test transmit done");
    for (int a = 0; a < 4; a++)
    begin
      pos  = (a == 3) ? $urandom % 8 : a * 7 % 8;
      n    = 1 + $urandom % 16;
      bits = 16'($urandom);
      wr(6'h0d, 8'(pos << 4));
      v = 8'h00;
      for (int k = 0; k < n; k++)
      begin
        v[pos] = bits[k];
        pos    = (pos + 1) % 8;
        if (pos == 0) begin q.push_back(v); v = 8'h00; end
      end
      if (pos != 0) q.push_back(v);
      u_far.send(bits, n);
      for (int k = 0; k < 20 && (k == 0 || v != q.size()); k++) rd(6'h0a, v);
      exp_rd(6'h0c, 8'(pos), 8'h07);
      pops(q.size());
    end
    $display("test receive done");
    final_report();
  end
endmodule : fbf_top_tb
